/* File: radio_ctrl_cfg.svh */
// offsets, field positions, reset values and timing of the radio config bank
`ifndef RADIO_CTRL_CFG_SVH
`define RADIO_CTRL_CFG_SVH

`define ADDR_W 10
`define OFF_FRONTEND 10'h100
`define OFF_CCA_THR 10'h105
`define OFF_CCA_MODE 10'h106
`define OFF_BUF_BEH 10'h107
`define OFF_PKT_CFG 10'h108
`define OFF_RX_DLY 10'h109
`define OFF_TX_DLY 10'h10A
`define OFF_DLY_EXT 10'h10B

`define RST_FRONTEND 8'h00
`define RST_CCA_THR 8'hAB
`define RST_CCA_MODE 8'h00
`define RST_BUF_BEH 8'h00
`define RST_PKT_CFG 8'h04
`define RST_RX_DLY 8'hC0
`define RST_TX_DLY 8'hC0
`define RST_DLY_EXT 8'h00

`define B_AMP_STYLE 7
`define B_RX_AUTO 4
`define B_TX_AUTO 3
`define B_AMP_AUTO 2
`define B_CCA_CONT 2
`define B_CCA_RXENT 1
`define B_DLY_OFF 7
`define F_TX_REP 5:4
`define B_TX_THEN_RX 3
`define B_RX_THEN_TX 2
`define F_RX_STORE 1:0
`define B_ADDON 4
`define B_SYNTH_SKIP 3
`define B_FCS_OFF 0

`define CLK_NS 4
`define US_NS 1000
`define CCA_PERIOD_US 128
`define EXT_UNIT_US 4

`endif

/* File: radio_ctrl_pkg.sv */
// types shared by the radio config bank and its users
package radio_ctrl_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX_WAIT = 5'h02,
        ST_RX = 5'h04,
        ST_TX_WAIT = 5'h08,
        ST_TX = 5'h10
    } seq_state_t;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic rx_cmd;
        logic tx_cmd;
        logic frame_rcvd;
        logic frame_sent;
        logic cca_done;
        logic [7:0] rssi;
    } radio_evt_t;
endpackage

/* File: radio_packet_control_regs.sv */
// radio packet control registers with a small sequencer they steer
//
// How it works
// - bit 7 picks fast or user amp ramp-down
// - rx pin auto-high in RX, else gpio
// - tx pin auto-high in TX, else gpio
// - amp auto-enabled in TX, else software bias
// - signed threshold, resets to -85
// - clear flag set when power below threshold
// - repeated check interrupt every 128 us
// - check interrupt 128 us after RX entry
// - disable bit bypasses both start delays
// - tx repeat: once, cyclic ramped, cyclic held
// - after transmit go to receive when set
// - after receive go to transmit when set
// - rx store: first only, overwrite, discard
// - firmware add-on enable bit, loaded first
// - synth settle skip, continuous transmit only
// - checksum auto: validate and append
// - checksum off: store and send unchanged
// - rx start delay, resets to 192 us
// - extension adds 4 us units both ways
// - tx start delay in 1 us, resets 192
`timescale 1ns/1ps
`include "radio_ctrl_cfg.svh"

module radio_packet_control_regs #(
    parameter int US_CYCLES = `US_NS / `CLK_NS,
    parameter int CCA_PERIOD_US = `CCA_PERIOD_US
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register port
    input wire radio_ctrl_pkg::reg_req_t req_in,
    output logic [7:0] rdata_out,
    // radio events
    input wire radio_ctrl_pkg::radio_evt_t evt_in,
    // software gpio and aux bias values
    input wire logic gpio_rx_value_in,
    input wire logic gpio_tx_value_in,
    input wire logic aux_amp_bias_in,
    // pins and controls
    output logic rx_switch_pin_out,
    output logic tx_switch_pin_out,
    output logic ext_amp_en_out,
    output logic amp_style_user_out,
    output logic amp_hold_on_out,
    output logic cca_irq_out,
    output logic channel_clear_flag_out,
    output logic rx_search_start_out,
    output logic store_frame_out,
    output logic fcs_auto_out,
    output logic addon_en_out,
    output logic synth_skip_out,
    output radio_ctrl_pkg::seq_state_t state_out
);
    import radio_ctrl_pkg::*;

    localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);
    localparam logic [7:0] CCA_LAST = 8'(CCA_PERIOD_US - 1);

    logic [7:0] frontend_ff;
    logic [7:0] cca_thr_ff;
    logic [7:0] cca_mode_ff;
    logic [7:0] buf_beh_ff;
    logic [7:0] pkt_cfg_ff;
    logic [7:0] rx_dly_ff;
    logic [7:0] tx_dly_ff;
    logic [7:0] dly_ext_ff;
    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic [7:0] pre_ff;
    logic us_tick;
    logic [10:0] dly_ff;
    logic [10:0] nxt_dly;
    logic [7:0] cont_ff;
    logic [7:0] rxent_ff;
    logic rxent_run_ff;
    logic hold_ff;
    logic nxt_hold;
    logic [1:0] tx_rep;
    logic [1:0] rx_store;

    assign tx_rep = buf_beh_ff[`F_TX_REP];
    assign rx_store = buf_beh_ff[`F_RX_STORE];

    function automatic logic [10:0] start_delay(input logic [7:0] base,
                                                input logic off,
                                                input logic [7:0] ext);
        logic [10:0] sum;
        sum = {3'h0, base} + {1'h0, ext, 2'h0};
        return off ? 11'h000 : sum;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register writes

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            frontend_ff <= `RST_FRONTEND;
            cca_thr_ff <= `RST_CCA_THR;
            cca_mode_ff <= `RST_CCA_MODE;
            buf_beh_ff <= `RST_BUF_BEH;
            pkt_cfg_ff <= `RST_PKT_CFG;
            rx_dly_ff <= `RST_RX_DLY;
            tx_dly_ff <= `RST_TX_DLY;
            dly_ext_ff <= `RST_DLY_EXT;
        end else if (req_in.wr) begin
            case (req_in.addr)
                `OFF_FRONTEND: frontend_ff <= req_in.wdata;
                `OFF_CCA_THR: cca_thr_ff <= req_in.wdata;
                `OFF_CCA_MODE: cca_mode_ff <= req_in.wdata;
                `OFF_BUF_BEH: buf_beh_ff <= req_in.wdata;
                `OFF_PKT_CFG: pkt_cfg_ff <= req_in.wdata;
                `OFF_RX_DLY: rx_dly_ff <= req_in.wdata;
                `OFF_TX_DLY: tx_dly_ff <= req_in.wdata;
                `OFF_DLY_EXT: dly_ext_ff <= req_in.wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, data in the following cycle, unmapped reads zero

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (req_in.rd) begin
            case (req_in.addr)
                `OFF_FRONTEND: rdata_out <= frontend_ff;
                `OFF_CCA_THR: rdata_out <= cca_thr_ff;
                `OFF_CCA_MODE: rdata_out <= cca_mode_ff;
                `OFF_BUF_BEH: rdata_out <= buf_beh_ff;
                `OFF_PKT_CFG: rdata_out <= pkt_cfg_ff;
                `OFF_RX_DLY: rdata_out <= rx_dly_ff;
                `OFF_TX_DLY: rdata_out <= tx_dly_ff;
                `OFF_DLY_EXT: rdata_out <= dly_ext_ff;
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // microsecond tick

    assign us_tick = (pre_ff == US_LAST);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || us_tick) begin
            pre_ff <= 8'h00;
        end else begin
            pre_ff <= pre_ff + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer; commands are taken only in idle

    always_comb begin
        nxt_state = state_ff;
        nxt_dly = dly_ff;
        nxt_hold = hold_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_hold = 1'b0;
                if (evt_in.rx_cmd) begin
                    nxt_state = ST_RX_WAIT;
                    nxt_dly = start_delay(rx_dly_ff, buf_beh_ff[`B_DLY_OFF],
                                          dly_ext_ff);
                end else if (evt_in.tx_cmd) begin
                    nxt_state = ST_TX_WAIT;
                    nxt_dly = start_delay(tx_dly_ff, buf_beh_ff[`B_DLY_OFF],
                                          dly_ext_ff);
                end
            end
            ST_RX_WAIT: begin
                if (dly_ff == 11'h000) begin
                    nxt_state = ST_RX;
                end else if (us_tick) begin
                    nxt_dly = dly_ff - 11'h001;
                end
            end
            ST_TX_WAIT: begin
                if (dly_ff == 11'h000) begin
                    nxt_state = ST_TX;
                end else if (us_tick) begin
                    nxt_dly = dly_ff - 11'h001;
                end
            end
            ST_RX: begin
                if (evt_in.frame_rcvd) begin
                    if (buf_beh_ff[`B_RX_THEN_TX]) begin
                        nxt_state = ST_TX_WAIT;
                        nxt_dly = start_delay(tx_dly_ff,
                                              buf_beh_ff[`B_DLY_OFF],
                                              dly_ext_ff);
                    end else if (rx_store == 2'h0) begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_TX: begin
                if (evt_in.frame_sent) begin
                    nxt_hold = 1'b0;
                    if (buf_beh_ff[`B_TX_THEN_RX]) begin
                        nxt_state = ST_RX_WAIT;
                        nxt_dly = start_delay(rx_dly_ff,
                                              buf_beh_ff[`B_DLY_OFF],
                                              dly_ext_ff);
                    end else if (tx_rep == 2'h1 || tx_rep == 2'h3) begin
                        nxt_state = ST_TX_WAIT;
                        nxt_hold = (tx_rep == 2'h3);
                        nxt_dly = start_delay(tx_dly_ff,
                                              buf_beh_ff[`B_DLY_OFF],
                                              dly_ext_ff);
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_dly = 11'h000;
                nxt_hold = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
            dly_ff <= 11'h000;
            hold_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            dly_ff <= nxt_dly;
            hold_ff <= nxt_hold;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins and amplifier control

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rx_switch_pin_out <= 1'b0;
            tx_switch_pin_out <= 1'b0;
            ext_amp_en_out <= 1'b0;
            amp_style_user_out <= 1'b0;
            amp_hold_on_out <= 1'b0;
            state_out <= ST_IDLE;
        end else begin
            rx_switch_pin_out <= frontend_ff[`B_RX_AUTO] ?
                (state_ff == ST_RX) : gpio_rx_value_in;
            tx_switch_pin_out <= frontend_ff[`B_TX_AUTO] ?
                (state_ff == ST_TX) : gpio_tx_value_in;
            ext_amp_en_out <= frontend_ff[`B_AMP_AUTO] ?
                ((state_ff == ST_TX) || hold_ff) : aux_amp_bias_in;
            amp_style_user_out <= frontend_ff[`B_AMP_STYLE];
            amp_hold_on_out <= hold_ff;
            state_out <= state_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear channel assessment

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !cca_mode_ff[`B_CCA_CONT]) begin
            cont_ff <= 8'h00;
        end else if (us_tick) begin
            cont_ff <= (cont_ff == CCA_LAST) ? 8'h00 : cont_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in || state_ff != ST_RX) begin
            rxent_ff <= 8'h00;
            rxent_run_ff <= cca_mode_ff[`B_CCA_RXENT] && !rst_in;
        end else if (us_tick && rxent_run_ff) begin
            rxent_ff <= rxent_ff + 8'h01;
            if (rxent_ff == CCA_LAST) begin
                rxent_run_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cca_irq_out <= 1'b0;
        end else begin
            cca_irq_out <= us_tick && (
                (cca_mode_ff[`B_CCA_CONT] && cont_ff == CCA_LAST) ||
                (state_ff == ST_RX && rxent_run_ff &&
                 rxent_ff == CCA_LAST));
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            channel_clear_flag_out <= 1'b0;
        end else if (evt_in.cca_done) begin
            channel_clear_flag_out <=
                ($signed(evt_in.rssi) < $signed(cca_thr_ff));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive start, frame store and packet options

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rx_search_start_out <= 1'b0;
            store_frame_out <= 1'b0;
            fcs_auto_out <= 1'b1;
            addon_en_out <= 1'b0;
            synth_skip_out <= 1'b0;
        end else begin
            rx_search_start_out <= (state_ff == ST_RX_WAIT) &&
                (dly_ff == 11'h000);
            store_frame_out <= (state_ff == ST_RX) && evt_in.frame_rcvd &&
                (rx_store == 2'h0 || rx_store == 2'h1);
            fcs_auto_out <= !pkt_cfg_ff[`B_FCS_OFF];
            addon_en_out <= pkt_cfg_ff[`B_ADDON];
            synth_skip_out <= pkt_cfg_ff[`B_SYNTH_SKIP] &&
                (tx_rep == 2'h1 || tx_rep == 2'h3);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_rx_bypass_cmd;
        state_ff == ST_IDLE && evt_in.rx_cmd && buf_beh_ff[`B_DLY_OFF];
    endsequence

    sequence s_rx_entered;
        state_ff == ST_RX_WAIT ##1 state_ff == ST_RX;
    endsequence

    chk_rx_pin_auto: assert property (
        frontend_ff[`B_RX_AUTO] && state_ff == ST_RX |=> rx_switch_pin_out)
        else $error("rx pin low in receive with auto on");

    chk_tx_pin_auto: assert property (
        frontend_ff[`B_TX_AUTO] && state_ff != ST_TX |=> !tx_switch_pin_out)
        else $error("tx pin high outside transmit with auto on");

    chk_amp_auto_tx: assert property (
        frontend_ff[`B_AMP_AUTO] && state_ff == ST_TX |=> ext_amp_en_out)
        else $error("amp not enabled in transmit");

    chk_clear_flag: assert property (
        evt_in.cca_done |=> channel_clear_flag_out ==
            ($signed($past(evt_in.rssi)) < $signed($past(cca_thr_ff))))
        else $error("clear flag disagrees with threshold");

    chk_delay_bypass: assert property (
        s_rx_bypass_cmd |=> s_rx_entered)
        else $error("bypassed delay not skipped");

    chk_tx_once_idle: assert property (
        state_ff == ST_TX && evt_in.frame_sent && tx_rep == 2'h0 &&
        !buf_beh_ff[`B_TX_THEN_RX] |=> state_ff == ST_IDLE)
        else $error("single transmit did not return idle");

    chk_tx_then_rx: assert property (
        state_ff == ST_TX && evt_in.frame_sent && buf_beh_ff[`B_TX_THEN_RX]
        |=> state_ff == ST_RX_WAIT)
        else $error("no receive after transmit");

    chk_rx_first_store: assert property (
        state_ff == ST_RX && evt_in.frame_rcvd && rx_store == 2'h0 &&
        !buf_beh_ff[`B_RX_THEN_TX] |=> state_ff == ST_IDLE && store_frame_out)
        else $error("first frame not stored then idle");

    chk_thr_readback: assert property (
        req_in.rd && req_in.addr == `OFF_CCA_THR |=>
            rdata_out == $past(cca_thr_ff))
        else $error("threshold readback wrong");
endmodule

/* File: radio_packet_control_regs_test.sv */
// self-checking testbench for the radio packet control register bank
`timescale 1ns/1ps
`include "radio_ctrl_cfg.svh"

module radio_packet_control_regs_test;
import radio_ctrl_pkg::*;

localparam int USC = 4;
localparam int CCAP = 4;
localparam logic [4:0] E_RX = 5'h10;
localparam logic [4:0] E_TX = 5'h08;
localparam logic [4:0] E_RCV = 5'h04;
localparam logic [4:0] E_SNT = 5'h02;
localparam logic [4:0] E_CCA = 5'h01;

logic ref_clk_in;
logic rst_in;
reg_req_t req;
radio_evt_t evt;
logic g_rx;
logic g_tx;
logic aux;
logic [7:0] rdata;
logic rx_pin;
logic tx_pin;
logic amp_en;
logic style;
logic hold;
logic irq;
logic flag;
logic search;
logic store;
logic fcs_auto;
logic addon;
logic skip;
seq_state_t st;
int err_count;
int tests_run;
int n;
int store_cnt;
logic [9:0] offs [8] = '{`OFF_FRONTEND, `OFF_CCA_THR, `OFF_CCA_MODE,
    `OFF_BUF_BEH, `OFF_PKT_CFG, `OFF_RX_DLY, `OFF_TX_DLY, `OFF_DLY_EXT};
logic [7:0] rsts [8] = '{8'h00, 8'hAB, 8'h00, 8'h00, 8'h04, 8'hC0,
    8'hC0, 8'h00};
// reserved bits per register, always written back at their reset value
logic [7:0] rsvd [8] = '{8'h63, 8'h00, 8'hF9, 8'h40, 8'hE6, 8'h00,
    8'h00, 8'h00};

radio_packet_control_regs #(.US_CYCLES(USC), .CCA_PERIOD_US(CCAP)) i_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req),
    .rdata_out(rdata), .evt_in(evt), .gpio_rx_value_in(g_rx),
    .gpio_tx_value_in(g_tx), .aux_amp_bias_in(aux),
    .rx_switch_pin_out(rx_pin), .tx_switch_pin_out(tx_pin),
    .ext_amp_en_out(amp_en), .amp_style_user_out(style),
    .amp_hold_on_out(hold), .cca_irq_out(irq),
    .channel_clear_flag_out(flag), .rx_search_start_out(search),
    .store_frame_out(store), .fcs_auto_out(fcs_auto),
    .addon_en_out(addon), .synth_skip_out(skip), .state_out(st));

////////////////////////////////////////////////////////////////////////
initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
end

always @(posedge ref_clk_in) begin
    if (store === 1'b1) store_cnt++;
end

task automatic check(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
        err_count++;
        $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
endtask

task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk_in);
    req.wr <= 1'b0;
endtask

task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk_in);
    req.rd <= 1'b0;
    #1 check("read data", rdata, exp);
endtask

task automatic pulse(input logic [4:0] m, input logic [7:0] r);
    @(posedge ref_clk_in);
    evt <= {m, r};
    @(posedge ref_clk_in);
    evt <= {5'h00, r};
endtask

task automatic do_reset;
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1;
endtask

task automatic wait_st(input seq_state_t s, output int c);
    c = 0;
    while (st !== s && c < 400) begin
        @(posedge ref_clk_in);
        #1 c++;
    end
endtask

task automatic wait_irq(output int c);
    c = 1;
    @(posedge ref_clk_in);
    #1;
    while (irq !== 1'b1 && c < 400) begin
        @(posedge ref_clk_in);
        #1 c++;
    end
endtask

task automatic cnt_irq(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
        @(posedge ref_clk_in);
        #1 if (irq === 1'b1) c++;
    end
endtask

// one command, one completion event, then where the sequencer lands
task automatic seq(input logic [7:0] cfg, input logic [4:0] cmd,
                   input seq_state_t in_st, input logic [4:0] ev,
                   input seq_state_t nxt, input int stores);
    int s0;
    do_reset;
    wr(`OFF_FRONTEND, 8'h1C);
    wr(`OFF_BUF_BEH, cfg);
    pulse(cmd, 8'h00);
    wait_st(in_st, n);
    check("bypassed start", n < 8, 1'b1);
    @(posedge ref_clk_in);
    #1 check("rx pin", rx_pin, in_st == ST_RX);
    check("tx pin", tx_pin, in_st == ST_TX);
    check("amp enable", amp_en, in_st == ST_TX);
    s0 = store_cnt;
    pulse(ev, 8'h00);
    wait_st(nxt, n);
    check("next state", n < 400, 1'b1);
    repeat (3) @(posedge ref_clk_in);
    #1 check("stored frames", store_cnt - s0, stores);
    check("state held", st, nxt);
    check("amp hold", hold,
          ev == E_SNT && cfg[5:4] == 2'h3 && !cfg[3]);
endtask

task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask

////////////////////////////////////////////////////////////////////////
initial begin
    logic [7:0] rs [4];
    logic ex [4];
    rs = '{8'hEF, 8'hF0, 8'h7F, 8'h80};
    ex = '{1'b1, 1'b0, 1'b0, 1'b1};
    rst_in = 1'b1;
    req = '0;
    evt = '0;
    g_rx = 1'b0;
    g_tx = 1'b0;
    aux = 1'b0;
    err_count = 0;
    tests_run = 0;
    store_cnt = 0;
    do_reset;
    for (int i = 0; i < 8; i++) rd_chk(offs[i], rsts[i]);
    wr(10'h10C, 8'h5A);
    rd_chk(10'h10C, 8'h00);
    for (int i = 0; i < 8; i++) wr(offs[i], rsts[i] ^ ~rsvd[i]);
    for (int i = 0; i < 8; i++) rd_chk(offs[i], rsts[i] ^ ~rsvd[i]);
    check("amp style", style, 1'b1);
    check("addon", addon, 1'b1);
    check("fcs auto", fcs_auto, 1'b0);
    check("synth skip", skip, 1'b1);
    wr(`OFF_BUF_BEH, 8'h00);
    wr(`OFF_PKT_CFG, 8'h0C);
    repeat (2) @(posedge ref_clk_in);
    #1 check("synth skip", skip, 1'b0);
    check("fcs auto", fcs_auto, 1'b1);
    do_reset;
    for (int i = 0; i < 8; i++) rd_chk(offs[i], rsts[i]);
    $display("done: registers");

    wr(`OFF_CCA_THR, 8'hF0);
    for (int i = 0; i < 4; i++) begin
        pulse(E_CCA, rs[i]);
        #1 check("clear flag", flag, ex[i]);
    end
    @(posedge ref_clk_in);
    g_rx <= 1'b1;
    g_tx <= 1'b1;
    aux <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 check("gpio rx", rx_pin, 1'b1);
    check("gpio tx", tx_pin, 1'b1);
    check("aux bias", amp_en, 1'b1);
    $display("done: flag and manual pins");

    seq(8'h80, E_RX, ST_RX, E_RCV, ST_IDLE, 1);
    seq(8'h81, E_RX, ST_RX, E_RCV, ST_RX, 1);
    seq(8'h82, E_RX, ST_RX, E_RCV, ST_RX, 0);
    seq(8'h84, E_RX, ST_RX, E_RCV, ST_TX, 1);
    seq(8'h88, E_TX, ST_TX, E_SNT, ST_RX, 0);
    seq(8'h80, E_TX, ST_TX, E_SNT, ST_IDLE, 0);
    seq(8'h90, E_TX, ST_TX, E_SNT, ST_TX, 0);
    seq(8'hB0, E_TX, ST_TX, E_SNT, ST_TX, 0);
    $display("done: sequencer");

    // delays of 2 us plus one 4 us extension, then 3 us plus one
    do_reset;
    wr(`OFF_RX_DLY, 8'h02);
    wr(`OFF_DLY_EXT, 8'h01);
    pulse(E_RX, 8'h00);
    n = 0;
    while (search !== 1'b1 && n < 400) begin
        @(posedge ref_clk_in);
        #1 n++;
    end
    check("rx delay", n >= 6 * USC - 6 && n <= 6 * USC + 4, 1'b1);
    do_reset;
    wr(`OFF_TX_DLY, 8'h03);
    wr(`OFF_DLY_EXT, 8'h01);
    pulse(E_TX, 8'h00);
    wait_st(ST_TX, n);
    check("tx delay", n >= 7 * USC - 4 && n <= 7 * USC + 6, 1'b1);
    $display("done: delays");

    do_reset;
    wr(`OFF_CCA_MODE, 8'h04);
    wait_irq(n);
    wait_irq(n);
    check("cca period", n, CCAP * USC);
    wr(`OFF_CCA_MODE, 8'h00);
    cnt_irq(3 * CCAP * USC, n);
    check("cca off", n, 0);
    do_reset;
    wr(`OFF_CCA_MODE, 8'h02);
    wr(`OFF_BUF_BEH, 8'h80);
    pulse(E_RX, 8'h00);
    wait_st(ST_RX, n);
    wait_irq(n);
    check("rx entry cca", n >= CCAP * USC - 5 && n <= CCAP * USC + 2,
          1'b1);
    cnt_irq(3 * CCAP * USC, n);
    check("rx entry once", n, 0);
    $display("done: channel assessment");
    final_report;
end

initial begin
    repeat (50000) @(posedge ref_clk_in);
    err_count++;
    final_report;
end

endmodule
